// >>> mqf_port_flow.sv
// Multi-queue FIFO write and read port flow with AHB-Lite control registers
`timescale 1ns/1ps
module mqf_port_flow #(
   parameter int DW    = 18,
   parameter int NQ    = 4,
   parameter int DEPTH = 8,
   parameter int DEVW  = 3,
   parameter int QW    = $clog2(NQ),
   parameter int RQW   = $clog2(NQ + 1),
   parameter int CW    = $clog2(DEPTH + 1),
   parameter int PW    = $clog2(DEPTH)
) (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic                  hready,
   input  wire logic [31:0]           hwdata,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   input  wire logic [DEVW-1:0]       device_id,
   input  wire logic                  wr_en,
   input  wire logic [DW-1:0]         wr_data,
   input  wire logic                  wr_sel,
   input  wire logic [DEVW+QW-1:0]    wr_sel_addr,
   input  wire logic                  rd_en,
   input  wire logic                  rd_sel,
   input  wire logic [DEVW+RQW-1:0]   rd_sel_addr,
   input  wire logic                  oe_n,
   output logic      [DW-1:0]         q_out,
   output logic                       q_out_oe,
   output logic                       output_valid_n,
   output logic                       output_valid_oe,
   output logic                       queue_full_n,
   output logic                       queue_full_oe,
   input  wire logic                  serial_enable_in,
   output logic                       serial_enable_out
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [DW-1:0]          mem_q [NQ][DEPTH];
   logic [PW-1:0]          wptr_q [NQ];
   logic [PW-1:0]          rptr_q [NQ];
   logic [CW-1:0]          cnt_q  [NQ];
   logic [CW-1:0]          cnt_d  [NQ];
   logic [QW-1:0]          wq_q;
   logic                   wr_own_q;
   logic [QW-1:0]          rq_q;
   logic                   rd_here_q;
   logic                   rd_dev_q;
   logic [QW-1:0]          rq_new_q;
   logic                   rd_here_new_q;
   logic                   rd_dev_new_q;
   logic                   rd_own_q;
   mqf_pkg::mqf_sw_t       sw_q;
   logic                   cfg_q;
   logic [DW-1:0]          q_out_q;
   logic                   ov_n_q;
   logic                   ff_n_q;
   logic [mqf_pkg::DROP_W-1:0] drop_q;
   logic                   bus_wr_q;
   logic [mqf_pkg::ADDR_W-1:0] bus_addr_q;
   logic [31:0]            hrdata_q;
   logic                   hreadyout_q;
   logic                   serial_out_q;

   function automatic logic dev_hit(input logic [DEVW-1:0] dev,
                                    input logic [DEVW-1:0] id);
      dev_hit = (dev == id);
   endfunction

   function automatic logic q_full(input logic [CW-1:0] c);
      q_full = (c == CW'(DEPTH));
   endfunction

   // ---------------------------------------------------------------
   // Port decode
   // ---------------------------------------------------------------
   wire             wr_take   = cfg_q & wr_sel;
   wire             rd_take   = cfg_q & rd_sel & (sw_q == mqf_pkg::SW_IDLE);
   wire [QW-1:0]    wsel_q    = wr_sel_addr[QW-1:0];
   wire             wsel_here = dev_hit(wr_sel_addr[DEVW+QW-1:QW], device_id);
   wire [RQW-1:0]   rsel_q    = rd_sel_addr[RQW-1:0];
   wire             rsel_dev  = dev_hit(rd_sel_addr[DEVW+RQW-1:RQW], device_id);
   wire             rsel_null = (rsel_q >= RQW'(NQ));
   wire [CW-1:0]    rd_cnt    = cnt_q[rq_q];
   wire [CW-1:0]    wr_cnt    = cnt_q[wq_q];
   wire             wr_do     = cfg_q & wr_en & wr_own_q & ~q_full(wr_cnt);
   wire             wr_drop   = cfg_q & wr_en & wr_own_q & q_full(wr_cnt);
   wire             rd_avail  = rd_here_q & (rd_cnt != '0);
   // consumed word lets new data fall through
   wire             pop_idle  = rd_avail & (rd_en | ov_n_q);
   wire             pop_en    = cfg_q & ((sw_q == mqf_pkg::SW_IDLE) ? pop_idle : rd_avail);
   wire [QW-1:0]    wq_d      = (wr_take & wsel_here) ? wsel_q : wq_q;
   wire             own_d     = wr_take ? wsel_here : wr_own_q;

   // every pop, forced or not, frees space
   always_comb begin
      for (int i = 0; i < NQ; i++) begin
         cnt_d[i] = cnt_q[i];
         if (wr_do && wq_q == QW'(i)) begin
            cnt_d[i] = cnt_d[i] + CW'(1);
         end
         if (pop_en && rq_q == QW'(i)) begin
            cnt_d[i] = cnt_d[i] - CW'(1);
         end
      end
   end

   // ---------------------------------------------------------------
   // Queue storage
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NQ; i++) begin
            wptr_q[i] <= '0;
            rptr_q[i] <= '0;
            cnt_q[i]  <= '0;
         end
      end else begin
         for (int i = 0; i < NQ; i++) begin
            cnt_q[i] <= cnt_d[i];
            if (wr_do && wq_q == QW'(i)) begin
               wptr_q[i] <= wptr_q[i] + PW'(1);
            end
            if (pop_en && rq_q == QW'(i)) begin
               rptr_q[i] <= rptr_q[i] + PW'(1);
            end
         end
      end
   end

   // No reset on the array: contents are unreadable until written
   always_ff @(posedge hclk) begin
      if (wr_do) begin
         mem_q[wq_q][wptr_q[wq_q]] <= wr_data;
      end
   end

   // ---------------------------------------------------------------
   // Write port and full flag
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wq_q     <= '0;
         wr_own_q <= 1'b0;
         ff_n_q   <= 1'b1;
      end else begin
         wq_q     <= wq_d;
         // floats when another device is selected
         wr_own_q <= own_d;
         ff_n_q   <= ~q_full(cnt_d[wq_d]);
      end
   end

   // ---------------------------------------------------------------
   // Read port: two-stage switch pipeline
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_q          <= mqf_pkg::SW_IDLE;
         rq_q          <= '0;
         rd_here_q     <= 1'b0;
         rd_dev_q      <= 1'b0;
         rq_new_q      <= '0;
         rd_here_new_q <= 1'b0;
         rd_dev_new_q  <= 1'b0;
         rd_own_q      <= 1'b0;
         ov_n_q        <= 1'b1;
         q_out_q       <= '0;
      end else begin
         if (pop_en) begin
            q_out_q <= mem_q[rq_q][rptr_q[rq_q]];
         end
         unique case (sw_q)
            mqf_pkg::SW_IDLE: begin
               if (rd_take) begin
                  sw_q          <= mqf_pkg::SW_FLUSH;
                  rq_new_q      <= rsel_null ? rq_q : rsel_q[QW-1:0];
                  rd_here_new_q <= rsel_dev & ~rsel_null;
                  rd_dev_new_q  <= rsel_dev;
               end
               if (pop_en) begin
                  ov_n_q   <= 1'b0;
                  rd_own_q <= 1'b1;
               // consumed last word is marked read
               end else if (rd_en && rd_dev_q) begin
                  ov_n_q <= 1'b1;
               end
            end
            mqf_pkg::SW_FLUSH: begin
               // one word from the prior queue
               sw_q      <= mqf_pkg::SW_FIRST;
               rq_q      <= rq_new_q;
               rd_here_q <= rd_here_new_q;
               rd_dev_q  <= rd_dev_new_q;
               if (pop_en) begin
                  ov_n_q <= 1'b0;
               end
            end
            mqf_pkg::SW_FIRST: begin
               sw_q <= mqf_pkg::SW_IDLE;
               if (pop_en) begin
                  ov_n_q   <= 1'b0;
                  rd_own_q <= 1'b1;
               end else begin
                  // empty or null: hold, mark read
                  ov_n_q <= 1'b1;
                  // hand read bus to the new device
                  if (!rd_dev_q) begin
                     rd_own_q <= 1'b0;
                  end
               end
            end
            default: begin
               sw_q <= mqf_pkg::SW_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ---------------------------------------------------------------
   wire        bus_act  = hsel & hready & htrans[mqf_pkg::HTRANS_ACT_BIT];
   wire [mqf_pkg::ADDR_W-1:0] a_addr = haddr[mqf_pkg::ADDR_W-1:0];
   logic [NQ-1:0] st_empty;
   logic [NQ-1:0] st_full;
   always_comb begin
      for (int i = 0; i < NQ; i++) begin
         st_empty[i] = (cnt_q[i] == '0);
         st_full[i]  = q_full(cnt_q[i]);
      end
   end
   wire [31:0] stat_word = (32'(st_empty))
                         | (32'(st_full) << mqf_pkg::STAT_FULL_LSB)
                         | (32'(wq_q) << mqf_pkg::STAT_WQ_LSB)
                         | (32'(rq_q) << mqf_pkg::STAT_RQ_LSB)
                         | (32'(ov_n_q) << mqf_pkg::STAT_OV_BIT)
                         | (32'(ff_n_q) << mqf_pkg::STAT_FF_BIT);
   wire [31:0] rd_mux =
      (a_addr == mqf_pkg::REG_CTRL)   ? (32'(cfg_q) << mqf_pkg::CTRL_CFG_BIT) :
      (a_addr == mqf_pkg::REG_STATUS) ? stat_word :
      (a_addr == mqf_pkg::REG_DROP)   ? 32'(drop_q) : 32'h0000_0000;
   wire        wr_ctrl  = bus_wr_q & (bus_addr_q == mqf_pkg::REG_CTRL);
   wire        clr_drop = bus_wr_q & (bus_addr_q == mqf_pkg::REG_DROP);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_wr_q    <= 1'b0;
         bus_addr_q  <= '0;
         hrdata_q    <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         cfg_q       <= mqf_pkg::CTRL_RESET;
         drop_q      <= mqf_pkg::DROP_RESET;
         serial_out_q <= 1'b1;
      end else begin
         hreadyout_q <= 1'b1;
         bus_wr_q    <= bus_act & hwrite;
         if (bus_act) begin
            bus_addr_q <= a_addr;
         end
         if (bus_act && !hwrite) begin
            hrdata_q <= rd_mux;
         end
         if (wr_ctrl) begin
            cfg_q <= hwdata[mqf_pkg::CTRL_CFG_BIT];
         end
         // Counting a refused write wins over a clear
         if (wr_drop) begin
            drop_q <= drop_q + mqf_pkg::DROP_W'(1);
         end else if (clr_drop) begin
            drop_q <= mqf_pkg::DROP_RESET;
         end
         // low once this and earlier devices are configured
         serial_out_q <= serial_enable_in | ~cfg_q;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign hrdata            = hrdata_q;
   assign hreadyout         = hreadyout_q;
   assign hresp             = mqf_pkg::HRESP_OKAY;
   assign q_out             = q_out_q;
   // output enable bypasses the clock on purpose
   assign q_out_oe          = rd_own_q & ~oe_n;
   assign output_valid_n    = ov_n_q;
   // valid flag driven only by the owning device
   assign output_valid_oe   = rd_own_q;
   assign queue_full_n      = ff_n_q;
   assign queue_full_oe     = wr_own_q;
   assign serial_enable_out = serial_out_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_switch;
      rd_take ##1 (sw_q == mqf_pkg::SW_FLUSH);
   endsequence
   sequence s_first_ready;
      (sw_q == mqf_pkg::SW_FIRST) && pop_en;
   endsequence

   property p_flush_pop;
      (sw_q == mqf_pkg::SW_FLUSH) && pop_en |=> !ov_n_q;
   endproperty
   a_flush_pop: assert property (p_flush_pop) else $error("flush word not presented");

   property p_first_word;
      s_switch ##1 s_first_ready |=> !ov_n_q && (sw_q == mqf_pkg::SW_IDLE);
   endproperty
   a_first_word: assert property (p_first_word) else $error("first word late");

   property p_hold;
      (sw_q == mqf_pkg::SW_IDLE) && !rd_en && !ov_n_q && !rd_take |=> $stable(q_out_q) && !ov_n_q;
   endproperty
   a_hold: assert property (p_hold) else $error("output moved with reads off");

   property p_empty_sel;
      (sw_q == mqf_pkg::SW_FIRST) && !pop_en |=> ov_n_q && $stable(q_out_q);
   endproperty
   a_empty_sel: assert property (p_empty_sel) else $error("empty queue select wrong");

   property p_no_full_write;
      wr_own_q && !ff_n_q |-> !wr_do;
   endproperty
   a_no_full_write: assert property (p_no_full_write) else $error("write taken while full");

   property p_sel_flag;
      wr_take && wsel_here |=> ff_n_q == !q_full(cnt_q[wq_q]);
   endproperty
   a_sel_flag: assert property (p_sel_flag) else $error("full flag not from new queue");

   property p_fill;
      wr_do && !wr_sel && (wr_cnt == CW'(DEPTH - 1)) && !(pop_en && rq_q == wq_q) |=> !ff_n_q;
   endproperty
   a_fill: assert property (p_fill) else $error("full flag not low on fill");

   property p_pop_frees;
      (sw_q != mqf_pkg::SW_IDLE) && pop_en && !(wr_do && wq_q == rq_q)
         |=> cnt_q[$past(rq_q)] == $past(rd_cnt) - CW'(1);
   endproperty
   a_pop_frees: assert property (p_pop_frees) else $error("forced read kept space");

   property p_stream;
      (sw_q == mqf_pkg::SW_IDLE) && rd_en && rd_avail && cfg_q |=> !ov_n_q && rd_own_q;
   endproperty
   a_stream: assert property (p_stream) else $error("enabled read not presented");

   property p_oe_async;
      oe_n |-> !q_out_oe;
   endproperty
   a_oe_async: assert property (p_oe_async) else $error("data driven with oe high");
endmodule

// >>> mqf_pkg.sv
// Shared constants for the multi-queue port flow block
package mqf_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL     = 8'h00;
   localparam logic [7:0]  REG_STATUS   = 8'h04;
   localparam logic [7:0]  REG_DROP     = 8'h08;
   localparam int          ADDR_W       = 8;
   localparam int          CTRL_CFG_BIT = 0;
   localparam logic        CTRL_RESET   = 1'b0;
   localparam logic [15:0] DROP_RESET   = 16'h0000;
   localparam int          DROP_W       = 16;
   localparam int          STAT_FULL_LSB = 8;
   localparam int          STAT_WQ_LSB  = 16;
   localparam int          STAT_RQ_LSB  = 20;
   localparam int          STAT_OV_BIT  = 24;
   localparam int          STAT_FF_BIT  = 25;
   // ---------------------------------------------------------------
   // AHB-Lite encodings
   // ---------------------------------------------------------------
   localparam int          HTRANS_ACT_BIT = 1;
   localparam logic        HRESP_OKAY   = 1'b0;
   // ---------------------------------------------------------------
   // Read queue switch sequence
   // ---------------------------------------------------------------
   localparam int          RD_SWITCH_LAT = 2;
   typedef enum logic [1:0] {
      SW_IDLE,
      SW_FLUSH,
      SW_FIRST
   } mqf_sw_t;
endpackage

// >>> mqf_host.sv
// Host model that drives the write and read ports of the queue block
`timescale 1ns/1ps
module mqf_host (
   input  wire logic        hclk,
   input  wire logic        serial_enable_out,
   output logic             wr_en,
   output logic [17:0]      wr_data,
   output logic             wr_sel,
   output logic [4:0]       wr_sel_addr,
   output logic             rd_en,
   output logic             rd_sel,
   output logic [5:0]       rd_sel_addr,
   output logic             oe_n,
   output logic             serial_enable_in
);
   int gap = 9;

   // ---------------------------------------------------------------
   // Port drivers
   // ---------------------------------------------------------------
   initial begin
      wr_en = 1'b0;
      wr_data = 18'h00000;
      wr_sel = 1'b0;
      wr_sel_addr = 5'h00;
      rd_en = 1'b0;
      rd_sel = 1'b0;
      rd_sel_addr = 6'h00;
      oe_n = 1'b0;
      serial_enable_in = 1'b0;
   end

   always @(posedge hclk) gap <= rd_sel ? 0 : gap + 1;

   task wait_cfg();
      int n;
      for (n = 0; n < 8 && serial_enable_out !== 1'b0; n++) @(posedge hclk);
   endtask

   task sel_wr(input logic [4:0] a);
      wait_cfg();
      @(posedge hclk);
      wr_sel <= 1'b1;
      wr_sel_addr <= a;
      @(posedge hclk);
      wr_sel <= 1'b0;
   endtask

   task sel_rd(input logic [5:0] a);
      wait_cfg();
      repeat (2) if (gap < 2) @(posedge hclk);
      @(posedge hclk);
      rd_sel <= 1'b1;
      rd_sel_addr <= a;
      @(posedge hclk);
      rd_sel <= 1'b0;
   endtask

   // Word may be dropped when full
   task push(input logic [17:0] d);
      wait_cfg();
      @(posedge hclk);
      wr_en <= 1'b1;
      wr_data <= d;
      @(posedge hclk);
      wr_en <= 1'b0;
   endtask

   task set_rd(input logic v);
      @(posedge hclk);
      rd_en <= v;
   endtask

   // No flop on the enable path: q_out_oe follows in the same step
   task set_oe(input logic v);
      @(posedge hclk);
      oe_n <= v;
   endtask

   task set_serial_enable_in(input logic v);
      @(posedge hclk);
      serial_enable_in <= v;
   endtask
endmodule

// >>> multi_queue_fifo_port_flow_tb_top.sv
// Self-checking bench for the queue port flow block with a queue model
`timescale 1ns/1ps
module multi_queue_fifo_port_flow_tb_top;
   logic        hclk = 1'b0;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [2:0]  dev_id;
   logic [31:0] stat_exp;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        wr_en, wr_sel, rd_en, rd_sel, oe_n;
   logic [17:0] wr_data;
   logic [4:0]  wr_sel_addr;
   logic [5:0]  rd_sel_addr;
   logic [17:0] q_out;
   logic        q_out_oe, output_valid_n, output_valid_oe;
   logic        queue_full_n, queue_full_oe;
   logic        serial_enable_in, serial_enable_out;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cur_rq = 0;
   logic [17:0] mdl [5][$];
   logic [17:0] last_q = 18'h00000;
   logic [31:0] rdv;

   always #12.5 hclk = ~hclk;

   mqf_port_flow #(.DW(18), .NQ(4), .DEPTH(8), .DEVW(3)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .device_id(dev_id), .wr_en(wr_en), .wr_data(wr_data),
      .wr_sel(wr_sel), .wr_sel_addr(wr_sel_addr), .rd_en(rd_en), .rd_sel(rd_sel),
      .rd_sel_addr(rd_sel_addr), .oe_n(oe_n), .q_out(q_out), .q_out_oe(q_out_oe),
      .output_valid_n(output_valid_n), .output_valid_oe(output_valid_oe),
      .queue_full_n(queue_full_n), .queue_full_oe(queue_full_oe),
      .serial_enable_in(serial_enable_in), .serial_enable_out(serial_enable_out));

   mqf_host u_host (
      .hclk(hclk), .serial_enable_out(serial_enable_out), .wr_en(wr_en), .wr_data(wr_data),
      .wr_sel(wr_sel), .wr_sel_addr(wr_sel_addr), .rd_en(rd_en), .rd_sel(rd_sel),
      .rd_sel_addr(rd_sel_addr), .oe_n(oe_n), .serial_enable_in(serial_enable_in));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] expv);
      comparisons++;
      if (seen !== expv) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expv);
      end
   endtask

   task give_verdict();
      $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task lapse();
      check(32'h0, 32'h1);
      give_verdict();
   endtask

   // Master never assumes a latency; it waits on hready under a bound
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      hsize <= 3'h2;
      n = 0;
      // Values read right after the edge are the ones the edge sampled
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      rd = hrdata;
      if (hreadyout !== 1'b1) lapse();
   endtask

   function logic pick(input int w);
      return (w == 0) ? queue_full_n : output_valid_oe;
   endfunction

   task wait_for(input int w, input logic v);
      int n;
      for (n = 0; n < 6 && pick(w) !== v; n++) begin
         @(posedge hclk);
         #1;
      end
      if (n == 6) lapse();
   endtask

   task push_w(input int q);
      logic [17:0] d;
      d = 18'($urandom);
      u_host.push(d);
      if (mdl[q].size() < 8) mdl[q].push_back(d);
   endtask

   task rd_switch(input int q);
      logic ov;
      u_host.sel_rd({3'h0, q[2:0]});
      @(posedge hclk);
      #1;
      if (mdl[cur_rq].size() > 0) last_q = mdl[cur_rq].pop_front();
      check({14'h0, q_out}, {14'h0, last_q});
      cur_rq = q;
      @(posedge hclk);
      #1;
      ov = (mdl[q].size() == 0);
      if (!ov) last_q = mdl[q].pop_front();
      check({14'h0, q_out}, {14'h0, last_q});
      check({31'h0, output_valid_n}, {31'h0, ov});
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      #2000000;
      lapse();
   end

   initial begin
      hresetn <= 1'b0;
      hsel    <= 1'b0;
      haddr   <= 32'h0000_0000;
      htrans  <= 2'h0;
      hwrite  <= 1'b0;
      hsize   <= 3'h2;
      hwdata  <= 32'h0000_0000;
      dev_id  <= 3'h0;
      void'($urandom(2215));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      check({14'h0, q_out}, 32'h0);
      check({29'h0, hresp, output_valid_n, queue_full_n}, 32'h3);
      check({31'h0, serial_enable_out}, 32'h1);
      ahb(1'b0, mqf_pkg::REG_CTRL, 32'h0, rdv);
      check(rdv, 32'h0);
      ahb(1'b0, 8'h0C, 32'h0, rdv);
      check(rdv, 32'h0);
      ahb(1'b1, mqf_pkg::REG_CTRL, 32'h1, rdv);
      ahb(1'b0, mqf_pkg::REG_CTRL, 32'h0, rdv);
      check(rdv, 32'h1);
      #1;
      check({31'h0, serial_enable_out}, 32'h0);
      u_host.set_serial_enable_in(1'b1);
      @(posedge hclk);
      #1;
      check({31'h0, serial_enable_out}, 32'h1);
      u_host.set_serial_enable_in(1'b0);
      @(posedge hclk);
      $display("test registers done");
      u_host.sel_wr(5'h01);
      #1;
      check({30'h0, queue_full_oe, queue_full_n}, 32'h3);
      repeat (8) push_w(1);
      wait_for(0, 1'b0);
      check({31'h0, queue_full_n}, 32'h0);
      push_w(1);
      ahb(1'b0, mqf_pkg::REG_DROP, 32'h0, rdv);
      check(rdv, 32'h1);
      // Queue 1 full, others empty, write queue 1, nothing read yet
      stat_exp = (32'h1 << mqf_pkg::STAT_OV_BIT) | (32'h1 << mqf_pkg::STAT_WQ_LSB)
               | (32'h2 << mqf_pkg::STAT_FULL_LSB) | 32'h0000_000D;
      ahb(1'b0, mqf_pkg::REG_STATUS, 32'h0, rdv);
      check(rdv, stat_exp);
      ahb(1'b1, mqf_pkg::REG_DROP, 32'h0, rdv);
      ahb(1'b0, mqf_pkg::REG_DROP, 32'h0, rdv);
      check(rdv, 32'h0);
      $display("test fill done");
      rd_switch(1);
      wait_for(0, 1'b1);
      check({31'h0, queue_full_n}, 32'h1);
      repeat (3) begin
         @(posedge hclk);
         #1;
         check({14'h0, q_out}, {14'h0, last_q});
      end
      u_host.set_rd(1'b1);
      repeat (7) begin
         @(posedge hclk);
         #1;
         last_q = mdl[1].pop_front();
         check({14'h0, q_out}, {14'h0, last_q});
      end
      u_host.set_rd(1'b0);
      #1;
      check({13'h0, output_valid_n, q_out}, {13'h0, 1'b1, last_q});
      push_w(1);
      @(posedge hclk);
      #1;
      last_q = mdl[1].pop_front();
      check({13'h0, output_valid_n, q_out}, {13'h0, 1'b0, last_q});
      $display("test stream done");
      u_host.sel_wr(5'h02);
      repeat (3) push_w(2);
      u_host.sel_wr(5'h03);
      repeat (3) push_w(3);
      rd_switch(2);
      rd_switch(3);
      rd_switch(4);
      repeat (2) @(posedge hclk);
      #1;
      check({13'h0, output_valid_n, q_out}, {13'h0, 1'b1, last_q});
      rd_switch(3);
      rd_switch(2);
      $display("test switch done");
      check({31'h0, q_out_oe}, 32'h1);
      u_host.set_oe(1'b1);
      #1;
      check({31'h0, q_out_oe}, 32'h0);
      u_host.set_oe(1'b0);
      #1;
      check({31'h0, q_out_oe}, 32'h1);
      u_host.sel_wr(5'h04);
      #1;
      check({31'h0, queue_full_oe}, 32'h0);
      u_host.sel_rd(6'h08);
      wait_for(1, 1'b0);
      check({30'h0, output_valid_oe, q_out_oe}, 32'h0);
      u_host.sel_wr(5'h00);
      push_w(0);
      u_host.sel_rd(6'h00);
      wait_for(1, 1'b1);
      last_q = mdl[0].pop_front();
      check({13'h0, output_valid_n, q_out}, {13'h0, 1'b0, last_q});
      // Same queue address now names this device under its new strap
      @(posedge hclk);
      dev_id <= 3'h1;
      u_host.sel_wr(5'h04);
      #1;
      check({30'h0, queue_full_oe, queue_full_n}, 32'h3);
      $display("test expansion done");
      give_verdict();
   end
endmodule
